// ### rtl/dcci_map.svh
/*
 Constants of the DDR2 command and control input front end.
 Assumes inclusion by bare name from every design file that needs them.
*/
// Functional notes
// - Sample address and control on rising true clock, which is mclk here.
// - Read data beats reference both directions of the clock crossing.
// - Clock enable high keeps clocks, input buffers and drivers active; low stops.
// - Enable low with banks idle enters precharge power-down or self refresh.
// - Power-down entry, exit and self-refresh entry are sampled on the clock.
// - Self-refresh exit is seen on the enable rise, without the clock; here state_reg leaves DCCI_SREF only on the next mclk rise.
// - Power-down leaves only clock, termination and clock enable buffers on.
// - Self refresh leaves only the clock enable buffer on.
// - Chip select high on an edge masks that edge's command.
// - Command decodes from row, column, write strobes with chip select.
// - Termination enable registered high switches on internal termination.
// - Termination covers only data, strobes, alternate strobe and mask pins.
// - Termination disabled in ext_mode_reg_1 makes the device ignore termination_enable.
// - Bank select picks bank for activate, read, write, precharge, and mode register.
// - Precharge samples precharge_all_bit: low one bank, high all banks.
// - Write beat discarded when write_mask sampled high with it, both edges.
`ifndef DCCI_MAP_SVH
`define DCCI_MAP_SVH
`define DCCI_CMD_MRS 4'h0
`define DCCI_CMD_REF 4'h1
`define DCCI_CMD_PRE 4'h2
`define DCCI_CMD_ACT 4'h3
`define DCCI_CMD_WR 4'h4
`define DCCI_CMD_RD 4'h5
`define DCCI_CMD_NOP 4'h7
`define DCCI_CMD_DESEL 4'h8
`define DCCI_BANKS_DEF 8
`define DCCI_BANK_W_DEF 3
`define DCCI_ADDR_W_DEF 14
`define DCCI_PALL_BIT 10
`define DCCI_TERM_PINS_X8 4'h3
`define DCCI_TERM_PINS_X16 4'hc
`define DCCI_MASK_LO 2'h1
`define DCCI_MASK_HI 2'h2
`endif

// ### rtl/dcci_pkg.sv
/*
 Types of the DDR2 command and control input front end.
 Assumes no surroundings beyond the tool's package support.
*/
package dcci_pkg;
    typedef enum logic [1:0] {
        DCCI_ACTIVE = 2'h0,
        DCCI_PDOWN = 2'h1,
        DCCI_SREF = 2'h3
    } dcci_state_type;
endpackage

// ### rtl/dcci_cmd_decode.sv
/*
 Registered command decoder of the command input front end.
 Assumes sample_en is driven by the input buffer enable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dcci_map.svh"
module dcci_cmd_decode
    import dcci_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic sample_en,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    output logic [3:0] cmd_reg
);
    function automatic logic [3:0] dcci_decode(input logic cs_n, input logic [2:0] rcw);
        logic [3:0] code;
        code = {1'b0, rcw};
        if (cs_n) begin
            code = `DCCI_CMD_DESEL;
        end
        return code;
    endfunction

    always_ff @(posedge mclk) begin
        if (reset) begin
            cmd_reg <= `DCCI_CMD_DESEL;
        end else if (sample_en) begin
            cmd_reg <= dcci_decode(chip_select_n,
                {row_strobe_n, column_strobe_n, write_strobe_n});
        end else begin
            cmd_reg <= `DCCI_CMD_DESEL;
        end
    end

    property p_desel;
        @(posedge mclk) disable iff (reset)
        (sample_en && chip_select_n) |=> (cmd_reg == `DCCI_CMD_DESEL);
    endproperty
    a_desel: assert property (p_desel) else $error("selected-off command not masked");

    property p_nop;
        @(posedge mclk) disable iff (reset)
        (sample_en && !chip_select_n && row_strobe_n && column_strobe_n && write_strobe_n)
            |=> (cmd_reg == `DCCI_CMD_NOP);
    endproperty
    a_nop: assert property (p_nop) else $error("nop not decoded");
endmodule
`default_nettype wire

// ### rtl/dcci_term_ctrl.sv
/*
 On-die termination control of the command input front end.
 Assumes width code and termination mode come from mode register logic.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dcci_map.svh"
module dcci_term_ctrl
    import dcci_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic sample_en,
    input wire logic termination_enable,
    input wire logic term_allowed,
    input wire logic wide_part,
    output logic term_on_reg,
    output logic [3:0] term_pins_reg
);
    always_ff @(posedge mclk) begin
        if (reset) begin
            term_on_reg <= 1'b0;
        end else if (!term_allowed) begin
            // Mode bit wins even while the pin buffer is off
            term_on_reg <= 1'b0;
        end else if (sample_en) begin
            term_on_reg <= termination_enable;
        end
    end

    // Pin groups: bit0 data, bit1 strobe+mask (x4/x8); bit2,3 byte lanes (x16)
    always_ff @(posedge mclk) begin
        if (reset) begin
            term_pins_reg <= 4'h0;
        end else begin
            term_pins_reg <= wide_part ? `DCCI_TERM_PINS_X16 : `DCCI_TERM_PINS_X8;
        end
    end

    property p_term_ignored;
        @(posedge mclk) disable iff (reset)
        !term_allowed |=> !term_on_reg;
    endproperty
    a_term_ignored: assert property (p_term_ignored) else $error("termination not ignored");
endmodule
`default_nettype wire

// ### rtl/dcci_front_end.sv
/*
 Command and control input front end of a DDR2 memory device: power state,
 input buffer gating, command decode, bank and precharge capture, write mask.
 Assumes mclk is the device's internal view of the true clock rising crossing.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dcci_map.svh"
module dcci_front_end
    import dcci_pkg::*;
#(
    parameter int BANKS = `DCCI_BANKS_DEF,
    parameter int BANK_W = `DCCI_BANK_W_DEF,
    parameter int ADDR_W = `DCCI_ADDR_W_DEF
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clock_enable_in,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [BANK_W-1:0] bank_select,
    input wire logic [ADDR_W-1:0] address,
    input wire logic termination_enable,
    input wire logic term_allowed,
    input wire logic wide_part,
    input wire logic [1:0] write_mask,
    input wire logic [1:0] write_beat_valid,
    output logic [1:0] power_state_reg,
    output logic clocks_active,
    output logic buf_main_en,
    output logic buf_clk_term_en,
    output logic [3:0] cmd_reg,
    output logic [BANK_W-1:0] bank_reg,
    output logic [ADDR_W-1:0] addr_reg,
    output logic [BANKS-1:0] precharge_banks_reg,
    output logic [BANKS-1:0] open_banks_reg,
    output logic term_on_reg,
    output logic [3:0] term_pins_reg,
    output logic [1:0] beat_write_reg,
    output logic read_beat_both_edges
);
    if (BANKS != (1 << BANK_W) || ADDR_W <= `DCCI_PALL_BIT) begin : g_width_check
        $error("dcci_front_end: bank or address width unsupported");
    end

    dcci_state_type state_reg;
    dcci_state_type state_next;
    logic sref_exit;
    logic all_idle;

    ////////////////////////////////////////////////////////////////////////////
    // Power state

    assign all_idle = (open_banks_reg == '0);
    // Self-refresh exit is the level of the enable pin, not a clocked sample
    assign sref_exit = (state_reg == DCCI_SREF) && clock_enable_in;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DCCI_ACTIVE: begin
                if (!clock_enable_in) begin
                    if (all_idle && cmd_reg == `DCCI_CMD_REF) begin
                        state_next = DCCI_SREF;
                    end else begin
                        state_next = DCCI_PDOWN;
                    end
                end
            end
            DCCI_PDOWN: begin
                if (clock_enable_in) begin
                    state_next = DCCI_ACTIVE;
                end
            end
            DCCI_SREF: begin
                if (sref_exit) begin
                    state_next = DCCI_ACTIVE;
                end
            end
            default: begin
                state_next = DCCI_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= DCCI_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign power_state_reg = state_reg;
    // Clock enable low stops clocks, main input buffers and drivers at once
    assign clocks_active = (state_reg == DCCI_ACTIVE) && clock_enable_in;
    assign buf_main_en = clocks_active;
    assign buf_clk_term_en = (state_reg != DCCI_SREF);
    // Both crossings of the clock pair carry a read beat
    assign read_beat_both_edges = clocks_active;

    ////////////////////////////////////////////////////////////////////////////
    // Command, bank and address capture

    dcci_cmd_decode u_dec (
        .mclk(mclk),
        .reset(reset),
        .sample_en(buf_main_en),
        .chip_select_n(chip_select_n),
        .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n),
        .write_strobe_n(write_strobe_n),
        .cmd_reg(cmd_reg)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            bank_reg <= '0;
            addr_reg <= '0;
        end else if (buf_main_en) begin
            bank_reg <= bank_select;
            addr_reg <= address;
        end
    end

    // Bank bookkeeping acts on the command registered one edge earlier
    always_ff @(posedge mclk) begin
        if (reset) begin
            precharge_banks_reg <= '0;
        end else if (cmd_reg == `DCCI_CMD_PRE) begin
            if (addr_reg[`DCCI_PALL_BIT]) begin
                precharge_banks_reg <= '1;
            end else begin
                precharge_banks_reg <= BANKS'(1) << bank_reg;
            end
        end else begin
            precharge_banks_reg <= '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            open_banks_reg <= '0;
        end else if (cmd_reg == `DCCI_CMD_ACT) begin
            open_banks_reg <= open_banks_reg | (BANKS'(1) << bank_reg);
        end else if (cmd_reg == `DCCI_CMD_PRE) begin
            if (addr_reg[`DCCI_PALL_BIT]) begin
                open_banks_reg <= '0;
            end else begin
                open_banks_reg <= open_banks_reg & ~(BANKS'(1) << bank_reg);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Termination and write mask

    dcci_term_ctrl u_term (
        .mclk(mclk),
        .reset(reset),
        .sample_en(buf_clk_term_en),
        .termination_enable(termination_enable),
        .term_allowed(term_allowed),
        .wide_part(wide_part),
        .term_on_reg(term_on_reg),
        .term_pins_reg(term_pins_reg)
    );

    // Bit 0 is the rising strobe beat, bit 1 the falling one
    always_ff @(posedge mclk) begin
        if (reset) begin
            beat_write_reg <= 2'h0;
        end else begin
            beat_write_reg <= write_beat_valid & ~write_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_pdown_entry;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_ACTIVE && !clock_enable_in && !all_idle)
            |=> (state_reg == DCCI_PDOWN);
    endproperty
    a_pdown_entry: assert property (p_pdown_entry) else $error("no active power-down");

    property p_sync_exit;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_PDOWN && clock_enable_in) |=> (state_reg == DCCI_ACTIVE);
    endproperty
    a_sync_exit: assert property (p_sync_exit) else $error("power-down exit missed");

    property p_sref_exit;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_SREF && clock_enable_in) |-> !clocks_active ##1 (state_reg == DCCI_ACTIVE);
    endproperty
    a_sref_exit: assert property (p_sref_exit) else $error("self-refresh exit missed");

    property p_buf_sref;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_SREF) |-> (!buf_main_en && !buf_clk_term_en);
    endproperty
    a_buf_sref: assert property (p_buf_sref) else $error("buffers on in self refresh");

    property p_buf_pdown;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_PDOWN) |-> (!buf_main_en && buf_clk_term_en);
    endproperty
    a_buf_pdown: assert property (p_buf_pdown) else $error("wrong buffers in power-down");

    property p_pre_all;
        @(posedge mclk) disable iff (reset)
        (cmd_reg == `DCCI_CMD_PRE && addr_reg[`DCCI_PALL_BIT]) |=> (open_banks_reg == '0);
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

    property p_mask;
        @(posedge mclk) disable iff (reset)
        write_mask[0] |=> !beat_write_reg[0];
    endproperty
    a_mask: assert property (p_mask) else $error("masked beat written");

    property p_cke_low;
        @(posedge mclk) disable iff (reset)
        !clock_enable_in |-> !clocks_active;
    endproperty
    a_cke_low: assert property (p_cke_low) else $error("clocks active with enable low");

    property p_sref_entry;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_ACTIVE && !clock_enable_in && all_idle && cmd_reg == `DCCI_CMD_REF)
            |=> (state_reg == DCCI_SREF);
    endproperty
    a_sref_entry: assert property (p_sref_entry) else $error("no self refresh");

    property p_pchg_pdown;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_ACTIVE && !clock_enable_in && all_idle && cmd_reg != `DCCI_CMD_REF)
            |=> (state_reg == DCCI_PDOWN);
    endproperty
    a_pchg_pdown: assert property (p_pchg_pdown) else $error("no power-down");

    property p_pdown_hold;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_PDOWN && !clock_enable_in) |=> (state_reg == DCCI_PDOWN);
    endproperty
    a_pdown_hold: assert property (p_pdown_hold) else $error("left power-down");

    property p_sref_hold;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_SREF && !clock_enable_in) |=> (state_reg == DCCI_SREF);
    endproperty
    a_sref_hold: assert property (p_sref_hold) else $error("left self refresh");

    property p_cmd_off;
        @(posedge mclk) disable iff (reset)
        (state_reg != DCCI_ACTIVE) |=> (cmd_reg == `DCCI_CMD_DESEL);
    endproperty
    a_cmd_off: assert property (p_cmd_off) else $error("command while off");

    property p_addr_hold;
        @(posedge mclk) disable iff (reset)
        !buf_main_en |=> ($stable(addr_reg) && $stable(bank_reg));
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address taken while off");

    property p_act_opens;
        @(posedge mclk) disable iff (reset)
        (cmd_reg == `DCCI_CMD_ACT) |=> open_banks_reg[$past(bank_reg)];
    endproperty
    a_act_opens: assert property (p_act_opens) else $error("activated bank not open");

    property p_pre_one;
        @(posedge mclk) disable iff (reset)
        (cmd_reg == `DCCI_CMD_PRE && !addr_reg[`DCCI_PALL_BIT])
            |=> ($onehot(precharge_banks_reg) && !open_banks_reg[$past(bank_reg)]);
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("single precharge wrong");

    property p_mask_hi;
        @(posedge mclk) disable iff (reset)
        write_mask[1] |=> !beat_write_reg[1];
    endproperty
    a_mask_hi: assert property (p_mask_hi) else $error("masked beat 1 written");

    property p_beat_kept;
        @(posedge mclk) disable iff (reset)
        (write_beat_valid[0] && !write_mask[0]) |=> beat_write_reg[0];
    endproperty
    a_beat_kept: assert property (p_beat_kept) else $error("unmasked beat lost");

    property p_cke_high;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_ACTIVE && clock_enable_in) |-> (clocks_active && buf_main_en);
    endproperty
    a_cke_high: assert property (p_cke_high) else $error("clocks stopped");

    property p_term_pdown;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_PDOWN)
            |=> (term_on_reg == ($past(termination_enable) && $past(term_allowed)));
    endproperty
    a_term_pdown: assert property (p_term_pdown) else $error("termination frozen");

    property p_term_sref;
        @(posedge mclk) disable iff (reset)
        (state_reg == DCCI_SREF && term_allowed) |=> $stable(term_on_reg);
    endproperty
    a_term_sref: assert property (p_term_sref) else $error("termination moved");
endmodule
`default_nettype wire

// ### tb/dcci_ctrl_model.sv
/*
 Memory controller model driving the command pins of the front end.
 Assumes the bench calls its tasks; pins change at falling mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module dcci_ctrl_model (
    input wire logic mclk,
    output logic cke,
    output logic [3:0] cmd_n,
    output logic [2:0] bank,
    output logic [13:0] addr
);
    initial begin
        cke = 1'b1;
        cmd_n = 4'hf;
        bank = 3'h0;
        addr = 14'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Cke never moves here, so accesses keep its current level
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge mclk);
        cmd_n = c;
        // Deselected rank sees floating lines
        bank = c[3] ? ~bank : b;
        addr = c[3] ? ~addr : a;
    endtask
    // Nop while switching power state
    task automatic set_cke(input logic v);
        @(negedge mclk);
        cke = v;
        cmd_n = 4'h7;
    endtask
endmodule
`default_nettype wire

// ### tb/dcci_front_end_bench.sv
/*
 Self-checking bench of the command and control input front end.
 Assumes the controller model in dcci_ctrl_model.sv.
*/
`timescale 1ns/10ps
`default_nettype none
module dcci_front_end_bench;
    import dcci_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic termination_enable = 1'b1;
    logic term_allowed = 1'b1;
    logic wide_part = 1'b0;
    logic [1:0] write_mask = 2'h0;
    logic [1:0] write_beat_valid = 2'h0;
    logic cke;
    logic [3:0] cmd_n;
    logic [2:0] bank;
    logic [13:0] addr;
    logic [1:0] power_state_reg;
    logic clocks_active;
    logic buf_main_en;
    logic buf_clk_term_en;
    logic [3:0] cmd_reg;
    logic [2:0] bank_reg;
    logic [13:0] addr_reg;
    logic [7:0] precharge_banks_reg;
    logic [7:0] open_banks_reg;
    logic term_on_reg;
    logic [3:0] term_pins_reg;
    logic [1:0] beat_write_reg;
    logic read_beat_both_edges;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #5 mclk = ~mclk;

    dcci_ctrl_model u_ctrl (.mclk(mclk), .cke(cke), .cmd_n(cmd_n), .bank(bank), .addr(addr));

    dcci_front_end u_dut (
        .mclk(mclk), .reset(reset), .clock_enable_in(cke), .chip_select_n(cmd_n[3]),
        .row_strobe_n(cmd_n[2]), .column_strobe_n(cmd_n[1]), .write_strobe_n(cmd_n[0]),
        .bank_select(bank), .address(addr), .termination_enable(termination_enable),
        .term_allowed(term_allowed), .wide_part(wide_part), .write_mask(write_mask),
        .write_beat_valid(write_beat_valid), .power_state_reg(power_state_reg),
        .clocks_active(clocks_active), .buf_main_en(buf_main_en),
        .buf_clk_term_en(buf_clk_term_en), .cmd_reg(cmd_reg), .bank_reg(bank_reg),
        .addr_reg(addr_reg), .precharge_banks_reg(precharge_banks_reg),
        .open_banks_reg(open_banks_reg), .term_on_reg(term_on_reg),
        .term_pins_reg(term_pins_reg), .beat_write_reg(beat_write_reg),
        .read_beat_both_edges(read_beat_both_edges)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("Checks %0d, errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Every code, deselected ones with command-like strobes too
    task automatic t_decode;
        for (int i = 0; i < 16; i++) begin
            u_ctrl.issue(i[3:0], 3'h1, 14'h0120 + 14'(i));
            @(negedge mclk);
            chk(16'(cmd_reg), i[3] ? 16'h8 : 16'(i[2:0]));
            if (!i[3]) begin
                chk(16'(addr_reg), 16'h0120 + 16'(i));
            end
        end
        chk(16'(open_banks_reg), 16'h2);
    endtask

    task automatic t_bank;
        u_ctrl.issue(4'h3, 3'h5, 14'h1abc);
        @(negedge mclk);
        chk(16'(bank_reg), 16'h5);
        @(negedge mclk);
        chk(16'(open_banks_reg), 16'h22);
        u_ctrl.issue(4'h2, 3'h5, 14'h0);
        repeat (2) @(negedge mclk);
        chk(16'(precharge_banks_reg), 16'h20);
        chk(16'(open_banks_reg), 16'h2);
    endtask

    // Row still open in bank one, so this is active power-down
    task automatic t_pdown;
        u_ctrl.set_cke(1'b0);
        #1;
        chk(16'(clocks_active), 16'h0);
        chk(16'(buf_main_en), 16'h0);
        @(negedge mclk);
        chk(16'(power_state_reg), 16'h1);
        chk(16'(buf_clk_term_en), 16'h1);
        chk(16'(read_beat_both_edges), 16'h0);
        u_ctrl.issue(4'h3, 3'h6, 14'h0);
        repeat (2) @(negedge mclk);
        chk(16'(cmd_reg), 16'h8);
        chk(16'(open_banks_reg), 16'h2);
        u_ctrl.set_cke(1'b1);
        @(negedge mclk);
        chk(16'(power_state_reg), 16'h0);
        chk(16'(read_beat_both_edges), 16'h1);
    endtask

    task automatic t_sref;
        u_ctrl.issue(4'h2, 3'h0, 14'h0400);
        repeat (2) @(negedge mclk);
        chk(16'(precharge_banks_reg), 16'hff);
        u_ctrl.issue(4'h1, 3'h0, 14'h0);
        u_ctrl.set_cke(1'b0);
        @(negedge mclk);
        chk(16'(power_state_reg), 16'h3);
        chk(16'(buf_clk_term_en), 16'h0);
        u_ctrl.set_cke(1'b1);
        #1;
        chk(16'(clocks_active), 16'h0);
        @(negedge mclk);
        chk(16'(power_state_reg), 16'h0);
        chk(16'(clocks_active), 16'h1);
        // All banks idle and no refresh: precharge power-down
        u_ctrl.set_cke(1'b0);
        @(negedge mclk);
        chk(16'(power_state_reg), 16'h1);
        u_ctrl.set_cke(1'b1);
        @(negedge mclk);
        chk(16'(power_state_reg), 16'h0);
    endtask

    task automatic t_term;
        for (int k = 0; k < 5; k++) begin
            @(negedge mclk);
            term_allowed = (k >= 2);
            wide_part = k[0];
            termination_enable = (k < 4);
            @(negedge mclk);
            chk(16'(term_on_reg), 16'(k >= 2 && k < 4));
            if (k == 2 || k == 3) begin
                chk(16'(term_pins_reg), k[0] ? 16'hc : 16'h3);
            end
        end
    endtask

    task automatic t_mask;
        for (int m = 0; m < 4; m++) begin
            @(negedge mclk);
            write_beat_valid = 2'h3;
            write_mask = m[1:0];
            @(negedge mclk);
            chk(16'(beat_write_reg), {14'h0, ~m[1:0]});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Whole run is under a hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        chk(16'(cmd_reg), 16'h8);
        chk(16'(clocks_active), 16'h1);
        t_decode();
        t_bank();
        t_pdown();
        t_sref();
        t_term();
        t_mask();
        summarize();
    end
endmodule
`default_nettype wire
